/* File: shared/tte_pkg.sv */
// constants shared by the two-tier event controller
package tte_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int N_SRC = 64;
  localparam int N_LVL = 16;
  localparam int GEN_LO = 7;
  localparam int GEN_HI = 15;
  localparam int N_GEN = GEN_HI - GEN_LO + 1;
  localparam int N_ASG = 8;
  localparam int ASG_W = 4;

  // ****************************************************************
  // register word offsets (byte address = offset)
  // ****************************************************************
  localparam logic [7:0] OFS_LATCH = 8'h00;
  localparam logic [7:0] OFS_UNMASK = 8'h04;
  localparam logic [7:0] OFS_PEND = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  localparam logic [7:0] OFS_RMASK0 = 8'h10;
  localparam logic [7:0] OFS_RMASK1 = 8'h14;
  localparam logic [7:0] OFS_RSTAT0 = 8'h18;
  localparam logic [7:0] OFS_RSTAT1 = 8'h1C;
  localparam logic [7:0] OFS_ASG0 = 8'h20;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h40;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h44;

  // ****************************************************************
  // fields and reset values
  // ****************************************************************
  localparam int CTRL_GEN_EN_BIT = 0;
  localparam logic [15:0] RST_UNMASK = 16'h0000;
  localparam logic [31:0] RST_RMASK = 32'h0000_0000;
  localparam logic RST_GEN_EN = 1'b1;
  localparam logic [3:0] RST_IRQ_MASK = 4'h0;
  localparam int IRQ_SET_BIT = 0;
  localparam int IRQ_ACC_BIT = 1;
  localparam int IRQ_CANCEL_BIT = 2;
  localparam int IRQ_REFUSE_BIT = 3;
  localparam int N_IRQ = 4;

  // field value v selects core level v + GEN_LO
  localparam logic [N_ASG*32-1:0] RST_ASG = {
    32'h0000_6552, 32'h2114_4444, 32'h4333_3333, 32'h3333_3222,
    32'h2222_2222, 32'h2111_1111, 32'h1111_1000, 32'h0000_0000
  };

endpackage

/* File: rtl/tte_router.sv */
// system event router: per-source unmask and level assignment
module tte_router
  import tte_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [N_SRC-1:0] src,
  input wire logic [N_SRC-1:0] unmask,
  input wire logic [N_ASG*32-1:0] assign_flat,
  output logic [N_GEN-1:0] gen_q,
  output logic [N_SRC-1:0] status_q
);

  logic [N_SRC-1:0] pass;
  logic [N_GEN-1:0] gen_d;

  assign pass = src & unmask;

  // a level is driven while any passed source is assigned to it
  always_comb begin
    gen_d = '0;
    for (int s = 0; s < N_SRC; s++) begin
      for (int g = 0; g < N_GEN; g++) begin
        if (pass[s] && assign_flat[s*ASG_W +: ASG_W] == ASG_W'(g)) begin
          gen_d[g] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      gen_q <= '0;
      status_q <= '0;
    end else if (ce) begin
      gen_q <= gen_d;
      status_q <= pass;
    end
  end

endmodule

/* File: rtl/tte_level_slot.sv */
// one core event level: rising-edge detect and latch bit
module tte_level_slot (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic gen_in,
  input wire logic accept,
  input wire logic cancel,
  output logic rise,
  output logic latch_q
);

  logic prev_q;

  assign rise = gen_in & ~prev_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prev_q <= 1'b0;
      latch_q <= 1'b0;
    end else if (ce) begin
      prev_q <= gen_in;
      // a new edge wins over acceptance or cancel in the same cycle
      latch_q <= rise | (latch_q & ~accept & ~cancel);
    end
  end

endmodule

/* File: rtl/tte_core_ctrl.sv */
// two-tier event controller top: router, core latch/unmask, bus slave
module tte_core_ctrl
  import tte_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic sv_mode,
  input wire logic [N_SRC-1:0] periph_evt,
  input wire logic core_accept,
  input wire logic core_return,
  output logic req_valid,
  output logic [3:0] req_level,
  output logic [N_LVL-1:0] event_nesting_pending,
  output logic irq
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic ack_q;
  logic [31:0] dat_q;
  logic [N_LVL-1:0] unmask_q;
  logic gen_en_q;
  logic [N_SRC-1:0] rmask_q;
  logic [N_ASG*32-1:0] asg_q;
  logic [N_IRQ-1:0] irq_stat_q;
  logic [N_IRQ-1:0] irq_mask_q;
  logic irq_q;
  logic [N_LVL-1:0] pend_q;
  logic req_valid_q;
  logic [3:0] req_level_q;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic bus_req;
  logic wr_go;
  logic [31:0] bmask;
  logic [31:0] wdat;
  logic sel_latch;
  logic sel_unmask;
  logic sel_ctrl;
  logic sel_rmask0;
  logic sel_rmask1;
  logic sel_asg;
  logic sel_istat;
  logic sel_event_unmask;
  logic sel_pend;
  logic sel_rstat0;
  logic sel_rstat1;
  logic take;
  logic rd_take;
  logic [2:0] asg_idx;

  assign bus_req = wb_cyc_i & wb_stb_i;
  // writes land at the edge where the master sees ack
  assign wr_go = bus_req & wb_we_i & ack_q & ce;
  assign bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wdat = wb_dat_i & bmask;
  assign sel_latch = wb_adr_i == OFS_LATCH;
  assign sel_unmask = wb_adr_i == OFS_UNMASK;
  assign sel_ctrl = wb_adr_i == OFS_CTRL;
  assign sel_rmask0 = wb_adr_i == OFS_RMASK0;
  assign sel_rmask1 = wb_adr_i == OFS_RMASK1;
  assign sel_asg = wb_adr_i[7:5] == OFS_ASG0[7:5] && wb_adr_i[1:0] == 2'h0;
  assign sel_istat = wb_adr_i == OFS_IRQ_STAT;
  assign sel_event_unmask = wb_adr_i == OFS_IRQ_MASK;
  assign sel_pend = wb_adr_i == OFS_PEND;
  assign sel_rstat0 = wb_adr_i == OFS_RSTAT0;
  assign sel_rstat1 = wb_adr_i == OFS_RSTAT1;
  assign asg_idx = wb_adr_i[4:2];

  // ce low holds ack as well: keep the bus idle while frozen,
  // or the master sees an ack whose write never lands
  assign take = bus_req & ~ack_q;
  assign rd_take = take & ~wb_we_i;

  // ****************************************************************
  // router and level slots
  // ****************************************************************
  logic [N_GEN-1:0] gen_lvl;
  logic [N_SRC-1:0] rstat;
  logic [N_GEN-1:0] slot_rise;
  logic [N_GEN-1:0] slot_latch;
  logic [N_LVL-1:0] latch_full;
  logic [N_LVL-1:0] accept_vec;
  logic [N_LVL-1:0] cancel_vec;
  logic [N_LVL-1:0] refuse_vec;
  logic latch_wr;

  tte_router u_router (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .src(periph_evt),
    .unmask(rmask_q),
    .assign_flat(asg_q),
    .gen_q(gen_lvl),
    .status_q(rstat)
  );

  genvar g;
  generate
    for (g = 0; g < N_GEN; g++) begin : g_slot
      tte_level_slot u_slot (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .ce(ce),
        .gen_in(gen_lvl[g]),
        .accept(accept_vec[g+GEN_LO]),
        .cancel(cancel_vec[g+GEN_LO]),
        .rise(slot_rise[g]),
        .latch_q(slot_latch[g])
      );
    end
  endgenerate

  assign latch_full = {slot_latch, {GEN_LO{1'b0}}};

  // cancel only in supervisor mode and only for masked levels
  assign latch_wr = wr_go & sel_latch;
  assign cancel_vec = (latch_wr & sv_mode) ? (wdat[N_LVL-1:0] & ~unmask_q) : '0;
  assign refuse_vec = latch_wr ? (wdat[N_LVL-1:0] & ~cancel_vec) : '0;

  // ****************************************************************
  // priority and nesting
  // ****************************************************************
  function automatic logic [4:0] first_set(input logic [N_LVL-1:0] v);
    logic [4:0] r;
    r = 5'h10;
    for (int i = N_LVL - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  logic [4:0] pend_top;
  logic [N_LVL-1:0] below_pend;
  logic [N_LVL-1:0] cand;
  logic [4:0] cand_top;
  logic acc_go;
  logic ret_go;
  logic [N_LVL-1:0] ret_vec;

  assign pend_top = first_set(pend_q);
  // only levels of higher priority than the active one may nest
  assign below_pend = (pend_top[4]) ? '1 : ((N_LVL'(1) << pend_top[3:0]) - N_LVL'(1));
  assign cand = latch_full & unmask_q & below_pend & {N_LVL{gen_en_q}};
  assign cand_top = first_set(cand);
  assign acc_go = core_accept & req_valid_q;
  assign accept_vec = acc_go ? (N_LVL'(1) << req_level_q) : '0;
  assign ret_go = core_return & ~pend_top[4];
  assign ret_vec = ret_go ? (N_LVL'(1) << pend_top[3:0]) : '0;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pend_q <= '0;
      req_valid_q <= 1'b0;
      req_level_q <= 4'h0;
    end else if (ce) begin
      pend_q <= (pend_q & ~ret_vec) | accept_vec;
      // drop the offer for a cycle after acceptance, latch updates meanwhile
      req_valid_q <= ~cand_top[4] & ~acc_go;
      req_level_q <= cand_top[3:0];
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      unmask_q <= RST_UNMASK;
      gen_en_q <= RST_GEN_EN;
      rmask_q <= {RST_RMASK, RST_RMASK};
      asg_q <= RST_ASG;
      irq_mask_q <= RST_IRQ_MASK;
    end else if (wr_go) begin
      if (sel_unmask) begin
        unmask_q <= (unmask_q & ~bmask[N_LVL-1:0]) | wdat[N_LVL-1:0];
      end
      if (sel_ctrl && wb_sel_i[0]) begin
        gen_en_q <= wb_dat_i[CTRL_GEN_EN_BIT];
      end
      if (sel_rmask0) begin
        rmask_q[31:0] <= (rmask_q[31:0] & ~bmask) | wdat;
      end
      if (sel_rmask1) begin
        rmask_q[63:32] <= (rmask_q[63:32] & ~bmask) | wdat;
      end
      if (sel_asg) begin
        asg_q[asg_idx*32 +: 32] <= (asg_q[asg_idx*32 +: 32] & ~bmask) | wdat;
      end
      if (sel_event_unmask) begin
        irq_mask_q <= (irq_mask_q & ~bmask[N_IRQ-1:0]) | wdat[N_IRQ-1:0];
      end
    end
  end

  // ****************************************************************
  // interrupt status
  // ****************************************************************
  logic [N_IRQ-1:0] irq_evt;
  logic [N_IRQ-1:0] irq_clr;
  logic [N_IRQ-1:0] irq_stat_d;

  assign irq_evt[IRQ_SET_BIT] = |slot_rise;
  assign irq_evt[IRQ_ACC_BIT] = acc_go;
  assign irq_evt[IRQ_CANCEL_BIT] = |(cancel_vec & latch_full);
  assign irq_evt[IRQ_REFUSE_BIT] = |refuse_vec;
  assign irq_clr = (wr_go & sel_istat) ? wdat[N_IRQ-1:0] : '0;
  // set beats clear when both land together
  assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_evt;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_q <= '0;
      irq_q <= 1'b0;
    end else if (ce) begin
      irq_stat_q <= irq_stat_d;
      irq_q <= |(irq_stat_d & irq_mask_q);
    end
  end

  // ****************************************************************
  // read mux and acknowledge
  // ****************************************************************
  logic [31:0] rdata;
  logic [31:0] latch_rd;
  logic [31:0] unmask_rd;
  logic [31:0] pend_rd;
  logic [31:0] ctrl_rd;
  logic [31:0] istat_rd;
  logic [31:0] event_unmask_rd;

  // outside supervisor mode the latch reads as zero
  assign latch_rd = sv_mode ? {16'h0000, latch_full} : 32'h0000_0000;
  assign unmask_rd = {16'h0000, unmask_q};
  assign pend_rd = {16'h0000, pend_q};
  assign ctrl_rd = {31'h0, gen_en_q};
  assign istat_rd = {28'h0, irq_stat_q};
  assign event_unmask_rd = {28'h0, irq_mask_q};
  assign rdata = sel_latch ? latch_rd :
                 sel_unmask ? unmask_rd :
                 sel_pend ? pend_rd :
                 sel_ctrl ? ctrl_rd :
                 sel_rmask0 ? rmask_q[31:0] :
                 sel_rmask1 ? rmask_q[63:32] :
                 sel_rstat0 ? rstat[31:0] :
                 sel_rstat1 ? rstat[63:32] :
                 sel_asg ? asg_q[asg_idx*32 +: 32] :
                 sel_istat ? istat_rd :
                 sel_event_unmask ? event_unmask_rd :
                 32'h0000_0000;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else if (ce) begin
      ack_q <= take;
      dat_q <= rd_take ? rdata : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign req_valid = req_valid_q;
  assign req_level = req_level_q;
  assign event_nesting_pending = pend_q;
  assign irq = irq_q;

endmodule

/* File: testbench/tte_monitor.sv */
// assertion checker on the event controller top ports
module tte_monitor
  import tte_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic core_accept,
  input wire logic core_return,
  input wire logic req_valid,
  input wire logic [3:0] req_level,
  input wire logic [N_LVL-1:0] event_nesting_pending
);
  timeunit 1ns;
  timeprecision 100ps;
  // ********
  // checks
  // ********
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
  endsequence
  sequence s_take;
    req_valid && core_accept && ce;
  endsequence
  a_ack_next: assert property (s_req |=> wb_ack_o) else $error("ack missing");
  a_ack_pulse: assert property (wb_ack_o && ce |=> !wb_ack_o) else $error("ack held");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  a_take_pend: assert property (s_take |=> event_nesting_pending[$past(req_level)] && !req_valid)
    else $error("accept not recorded");
  a_pend_keep: assert property (!core_return && ce |=>
    (event_nesting_pending | ~$past(event_nesting_pending)) == 16'hFFFF)
    else $error("pending dropped");
  a_pend_cause: assert property (!(req_valid && core_accept) |=>
    (~event_nesting_pending | $past(event_nesting_pending)) == 16'hFFFF)
    else $error("pending without accept");
  a_ret_drop: assert property (core_return && !core_accept && ce && |event_nesting_pending |=>
    $countones(event_nesting_pending) + 1 == $countones($past(event_nesting_pending)))
    else $error("return did not clear");
  // nesting only below the lowest active level
  a_prio_order: assert property (req_valid |->
    (event_nesting_pending & ~(16'hFFFE << req_level)) == 16'h0000)
    else $error("offer not above pending");
  a_level_range: assert property (req_valid |-> req_level >= 4'h7)
    else $error("level below general range");
endmodule

/* File: testbench/tte_far_model.sv */
// far side: peripheral event lines and core sequencer
module tte_far_model
  import tte_pkg::*;
(
  input wire logic clk_sys,
  input wire logic req_valid,
  output logic [N_SRC-1:0] periph_evt,
  output logic core_accept,
  output logic core_return
);
  timeunit 1ns;
  timeprecision 100ps;
  logic hold = 1'b0;
  int stall = 0;
  int waited = 0;
  initial begin
    periph_evt = '0;
    core_accept = 1'b0;
    core_return = 1'b0;
  end
  // ********
  // sources and sequencer
  // ********
  // two-cycle pulses so every line gives one clean rising edge
  task automatic pulse(input logic [N_SRC-1:0] m);
    periph_evt <= m;
    repeat (2) @(posedge clk_sys);
    periph_evt <= '0;
  endtask
  task automatic ret();
    core_return <= 1'b1;
    @(posedge clk_sys);
    core_return <= 1'b0;
  endtask
  // slow answers exercise an offer that must stand
  always @(posedge clk_sys) begin
    core_accept <= 1'b0;
    if (req_valid && !core_accept && !hold) begin
      waited <= waited + 1;
      if (waited >= stall) begin
        core_accept <= 1'b1;
        waited <= 0;
      end
    end
  end
endmodule

/* File: testbench/tte_core_ctrl_test.sv */
// self-checking bench for the two-tier event controller
module tte_core_ctrl_test
  import tte_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, sv = 1'b1;
  logic ce = 1'b1;
  logic [3:0] sel = 4'hF;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, q, wb_dat_o;
  logic wb_ack_o, acc, ret, req_valid, irq;
  logic [3:0] req_level;
  logic [N_LVL-1:0] pend;
  logic [N_SRC-1:0] evt;
  int miscompares = 0, tests_run = 0, cycles = 0, n;
  int src_t[11] = '{0, 1, 11, 23, 35, 47, 53, 55, 57, 59, 63};
  logic [3:0] lvl_t[11] = '{4'h7, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'h8, 4'h9, 4'hC, 4'hD, 4'h7};
  initial forever #12.5 clk_sys = ~clk_sys;
  tte_core_ctrl uut (.clk_sys, .rst_b, .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o, .wb_dat_o,
    .sv_mode(sv), .periph_evt(evt), .core_accept(acc), .core_return(ret), .req_valid,
    .req_level, .event_nesting_pending(pend), .irq);
  tte_far_model pm (.clk_sys, .req_valid, .periph_evt(evt), .core_accept(acc),
    .core_return(ret));
  // ********
  // tasks
  // ********
  task automatic summarize();
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic run(input int s, input logic [3:0] l);
    pm.pulse(64'h1 << s);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (req_valid !== 1'b1 && n < 20);
    chk("offer delay", 1, n >= 2 && n <= 8);
    chk("level", l, req_level);
    repeat (6) @(posedge clk_sys);
    chk("pending", 16'h1 << l, pend);
    pm.ret();
    repeat (2) @(posedge clk_sys);
    chk("pending off", 0, pend);
    rd(OFS_LATCH, 32'h0, "latch cleared");
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      summarize();
    end
  end
  // ********
  // sequence
  // ********
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    rd(OFS_UNMASK, {16'h0, RST_UNMASK}, "unmask reset");
    rd(OFS_RMASK1, RST_RMASK, "router mask reset");
    rd(OFS_ASG0 + 8'h1C, RST_ASG[255:224], "assign word 7");
    rd(OFS_ASG0 + 8'h08, RST_ASG[95:64], "assign word 2");
    rd(8'hF0, 32'h0, "unmapped");
    wb(1'b1, OFS_UNMASK, 32'hFF80);
    wb(1'b1, OFS_RMASK0, 32'hFFFF_FFFF);
    wb(1'b1, OFS_RMASK1, 32'hFFFF_FFFF);
    for (int i = 0; i < 11; i++) begin
      pm.stall = i % 3;
      run(src_t[i], lvl_t[i]);
    end
    chk("irq masked", 0, irq);
    wb(1'b1, OFS_IRQ_MASK, 32'hF);
    @(posedge clk_sys);
    chk("irq raised", 1, irq);
    wb(1'b1, OFS_IRQ_STAT, 32'hF);
    @(posedge clk_sys);
    chk("irq cleared", 0, irq);
    wb(1'b1, OFS_ASG0 + 8'h1C, 32'h0000_0552);
    run(59, 4'h7);
    pm.hold = 1'b1;
    pm.pulse((64'h1 << 35) | 64'h1);
    repeat (6) @(posedge clk_sys);
    chk("first level", 7, req_level);
    wb(1'b1, OFS_UNMASK, 32'hFB80);
    rd(OFS_LATCH, 32'h0480, "latch both");
    sv <= 1'b0;
    rd(OFS_LATCH, 32'h0, "latch user read");
    wb(1'b1, OFS_LATCH, 32'h0400);
    sv <= 1'b1;
    rd(OFS_LATCH, 32'h0480, "latch user write");
    wb(1'b1, OFS_LATCH, 32'h0480);
    rd(OFS_LATCH, 32'h0080, "latch cancel");
    pm.hold = 1'b0;
    repeat (6) @(posedge clk_sys);
    chk("pending lowest", 16'h0080, pend);
    pm.ret();
    rd(OFS_IRQ_STAT, 32'hF, "irq status");
    // global enable off: the edge latches but is not offered
    wb(1'b1, OFS_CTRL, 32'h0);
    pm.pulse(64'h1 << 11);
    repeat (6) @(posedge clk_sys);
    chk("offer while disabled", 0, req_valid);
    rd(OFS_LATCH, 32'h0100, "latch while disabled");
    wb(1'b1, OFS_CTRL, 32'h1);
    repeat (6) @(posedge clk_sys);
    rd(OFS_PEND, 32'h0100, "pending readback");
    pm.ret();
    // frozen clock enable: an event seen only while ce is low is lost
    ce <= 1'b0;
    pm.pulse(64'h1 << 12);
    repeat (4) @(posedge clk_sys);
    chk("offer frozen", 0, req_valid);
    ce <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("pending frozen", 0, pend);
    rd(OFS_LATCH, 32'h0, "latch frozen");
    sel <= 4'h2;
    wb(1'b1, OFS_UNMASK, 32'h0);
    sel <= 4'hF;
    rd(OFS_UNMASK, 32'h0080, "unmask byte write");
    pm.periph_evt <= 64'h1 << 40;
    @(posedge clk_sys);
    rd(OFS_RSTAT1, 32'h0100, "router status");
    pm.periph_evt <= '0;
    rd(OFS_LATCH, 32'h0400, "latch masked level");
    wb(1'b1, OFS_LATCH, 32'h0400);
    rd(OFS_LATCH, 32'h0, "latch cancel masked");
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("pending in reset", 0, pend);
    chk("offer in reset", 0, req_valid);
    chk("irq in reset", 0, irq);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    rd(OFS_UNMASK, 32'h0, "unmask again");
    rd(OFS_RMASK0, RST_RMASK, "router mask again");
    summarize();
  end
endmodule
bind tte_core_ctrl tte_monitor mon (.clk_sys, .rst_b, .ce, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .wb_dat_o, .core_accept, .core_return, .req_valid, .req_level, .event_nesting_pending);
